// File: inc/mtio_consts.svh
// offsets, fields, reset values and counts of the motion task i/o
// assumes inclusion by bare name
`ifndef MTIO_CONSTS_SVH
`define MTIO_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MTIO_OFF_CTRL 8'h00
`define MTIO_OFF_JOG 8'h04
`define MTIO_OFF_WIN 8'h08
`define MTIO_OFF_STAT 8'h0c
`define MTIO_OFF_IRQ 8'h10
`define MTIO_OFF_MASK 8'h14
`define MTIO_OFF_CMP0 8'h18
`define MTIO_OFF_CMODE 8'h30

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define MTIO_CTRL_BASE_NEXT 0
`define MTIO_CTRL_BASE_RES 1
`define MTIO_CTRL_JOG_MODE 2
`define MTIO_CTRL_SEQ_LSB 3
`define MTIO_CTRL_W 5

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define MTIO_STAT_REACHED 0
`define MTIO_STAT_FERR 1
`define MTIO_STAT_SEQ 2
`define MTIO_STAT_PEND 3
`define MTIO_STAT_STATE_LSB 4
`define MTIO_STAT_TASK_LSB 8
`define MTIO_STAT_CMP_LSB 16

// ----------------------------------------------------------------
// interrupt events
// ----------------------------------------------------------------
`define MTIO_EV_START 0
`define MTIO_EV_REACHED 1
`define MTIO_EV_FERR 2
`define MTIO_EV_SEQ 3
`define MTIO_EV_JOG_END 4
`define MTIO_EV_W 5

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define MTIO_CTRL_RST 5'h00
`define MTIO_JOG_RST 32'h00000000
`define MTIO_WIN_RST 32'h00000010
`define MTIO_CMODE_RST 12'h000
// 1000 ns at the 100 ns clock
`define MTIO_SEQ_PULSE_CYC 10

`endif

// File: inc/mtio_pkg.sv
// types of the motion task i/o expansion logic
// assumes nothing beyond a systemverilog compiler
package mtio_pkg;

  typedef enum logic [1:0] {
    mtio_st_idle = 2'b00,
    mtio_st_move = 2'b01,
    mtio_st_jog = 2'b10
  } mtio_state_t;

  typedef enum logic [1:0] {
    mtio_seq_toggle = 2'b00,
    mtio_seq_pulse = 2'b01,
    mtio_seq_level = 2'b10
  } mtio_seq_mode_t;

endpackage

// File: design/mtio_poscmp.sv
// one position register comparator with a registered result
// assumes a synchronous position word from the motion core
`timescale 1ns/100ps
module mtio_poscmp
  import mtio_pkg::*;
#(
  parameter int PW = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [PW-1:0] position,
  input wire logic signed [PW-1:0] threshold,
  input wire logic enable,
  input wire logic above,
  output logic hit
);

  // a disabled comparator reads low rather than holding its last state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hit <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        hit <= 1'b0;
      end else if (above) begin
        hit <= (position >= threshold);
      end else begin
        hit <= (position < threshold);
      end
    end
  end

endmodule

// File: design/mtio_top.sv
// motion task i/o expansion: plc start, resume and jog inputs in,
// task commands to the motion core out, status outputs back to the plc
// assumes all inputs synchronous to ref_clk; registers on avalon-mm
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "mtio_consts.svh"

// Behaviour
// - next task starts only after target reached
// - base unit input may also start next
// - jog edge starts, falling edge aborts motion
// - jog speed sign gives direction, magnitude speed
// - resume continues interrupted task, base too
// - selected start launches task on select inputs
// - target reached high inside in-position window
// - sequence output toggles per sequenced task start
// - first sequence task forces sequence output low
// - sequence output form selectable by software
// - position compare outputs high when satisfied
module mtio_top
  import mtio_pkg::*;
#(
  parameter int PW = 32,
  parameter int NCMP = 6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [7:0] task_select,
  input wire logic next_task_start,
  input wire logic resume_task,
  input wire logic selected_task_start,
  input wire logic jog_start,
  input wire logic following_error_clear,
  input wire logic base_next_start,
  input wire logic base_resume,
  input wire logic signed [PW-1:0] core_act_pos,
  input wire logic signed [PW-1:0] core_tgt_pos,
  input wire logic core_task_active,
  input wire logic core_task_interrupted,
  input wire logic core_seq_begin,
  input wire logic core_seq_first,
  input wire logic core_following_error,
  output logic target_reached,
  output logic sequence_step_toggle,
  output logic following_error_out,
  output logic position_compare_0,
  output logic position_compare_1,
  output logic position_compare_2,
  output logic position_compare_3,
  output logic position_compare_4,
  output logic position_compare_5,
  output logic cmd_task_start,
  output logic [7:0] cmd_task_num,
  output logic cmd_next_start,
  output logic cmd_resume,
  output logic cmd_jog_run,
  output logic cmd_jog_dir,
  output logic [PW-1:0] cmd_jog_speed,
  output logic cmd_fe_clear
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [PW-1:0] mtio_abs(input logic signed [PW-1:0] v);
    mtio_abs = v[PW-1] ? PW'(-v) : PW'(v);
  endfunction

  function automatic logic [31:0] mtio_be(input logic [31:0] old);
    mtio_be = old;
    for (int i = 0; i < 4; i++) begin
      if (avs_byteenable[i]) begin
        mtio_be[i*8 +: 8] = avs_writedata[i*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  localparam int SEQ_CYC = `MTIO_SEQ_PULSE_CYC;
  localparam int SCW = $clog2(SEQ_CYC + 1);

  logic [`MTIO_CTRL_W-1:0] ctrl;
  logic [31:0] jog_speed;
  logic [31:0] win;
  logic [`MTIO_EV_W-1:0] irq_stat;
  logic [`MTIO_EV_W-1:0] irq_mask;
  logic [31:0] cmp_thr [NCMP];
  logic [2*NCMP-1:0] cmode;
  logic [NCMP-1:0] cmp_hit;
  mtio_state_t state;
  logic pending;
  logic prev_next, prev_resume, prev_sel, prev_jog, prev_fec;
  logic prev_bnext, prev_bres, prev_reached, prev_ferr;
  logic [SCW-1:0] seq_cnt;
  logic [31:0] next_rd;
  logic wr_do;
  logic rd_do;
  logic [`MTIO_EV_W-1:0] ev;
  logic [`MTIO_EV_W-1:0] next_irq_stat;
  logic next_req, resume_req, sel_req, jog_rise, jog_fall, fe_now;
  mtio_seq_mode_t seq_mode;

  assign seq_mode = mtio_seq_mode_t'(ctrl[`MTIO_CTRL_SEQ_LSB +: 2]);
  // the bus handshake completes on the edge that sees waitrequest low
  assign wr_do = avs_write & ~avs_waitrequest;
  assign rd_do = avs_read & ~avs_waitrequest;

  // ----------------------------------------------------------------
  // input edges
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {prev_next, prev_resume, prev_sel, prev_jog, prev_fec, prev_bnext,
       prev_bres} <= 7'h00;
    end else if (ce) begin
      {prev_next, prev_resume, prev_sel, prev_jog, prev_fec, prev_bnext,
       prev_bres} <= {next_task_start, resume_task, selected_task_start,
                      jog_start, following_error_clear, base_next_start,
                      base_resume};
    end
  end

  assign next_req = (next_task_start & ~prev_next)
      | (ctrl[`MTIO_CTRL_BASE_NEXT] & base_next_start & ~prev_bnext);
  assign resume_req = (resume_task & ~prev_resume)
      | (ctrl[`MTIO_CTRL_BASE_RES] & base_resume & ~prev_bres);
  assign sel_req = selected_task_start & ~prev_sel;
  assign jog_rise = jog_start & ~prev_jog;
  assign jog_fall = ~jog_start & prev_jog;
  assign fe_now = core_following_error;

  // ----------------------------------------------------------------
  // task commands
  // ----------------------------------------------------------------
  // a jog in progress owns the axis, so task starts are ignored meanwhile
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= mtio_st_idle;
      pending <= 1'b0;
      cmd_task_start <= 1'b0;
      cmd_task_num <= 8'h00;
      cmd_next_start <= 1'b0;
      cmd_resume <= 1'b0;
      cmd_jog_run <= 1'b0;
    end else if (ce) begin
      cmd_task_start <= 1'b0;
      cmd_next_start <= 1'b0;
      cmd_resume <= 1'b0;
      case (state)
        mtio_st_idle, mtio_st_move: begin
          if (ctrl[`MTIO_CTRL_JOG_MODE] && jog_rise) begin
            cmd_jog_run <= 1'b1;
            pending <= 1'b0;
            state <= mtio_st_jog;
          end else if (sel_req) begin
            cmd_task_start <= 1'b1;
            cmd_task_num <= task_select;
            pending <= 1'b0;
            state <= mtio_st_move;
          end else if (pending && target_reached) begin
            cmd_next_start <= 1'b1;
            pending <= 1'b0;
            state <= mtio_st_move;
          end else begin
            if (next_req) begin
              pending <= 1'b1;
            end
            if (resume_req && core_task_interrupted) begin
              cmd_resume <= 1'b1;
              state <= mtio_st_move;
            end else if (state == mtio_st_move && !core_task_active
                         && target_reached) begin
              state <= mtio_st_idle;
            end
          end
        end
        mtio_st_jog: begin
          if (jog_fall || !ctrl[`MTIO_CTRL_JOG_MODE]) begin
            cmd_jog_run <= 1'b0;
            state <= mtio_st_idle;
          end
        end
        default: begin
          cmd_jog_run <= 1'b0;
          state <= mtio_st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // jog speed and direction
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_jog_dir <= 1'b0;
      cmd_jog_speed <= '0;
    end else if (ce) begin
      cmd_jog_dir <= jog_speed[PW-1];
      cmd_jog_speed <= mtio_abs(PW'(jog_speed));
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      target_reached <= 1'b0;
      following_error_out <= 1'b1;
      cmd_fe_clear <= 1'b0;
      prev_reached <= 1'b0;
      prev_ferr <= 1'b0;
    end else if (ce) begin
      target_reached <= mtio_abs(core_act_pos - core_tgt_pos)
          <= PW'(win);
      following_error_out <= ~fe_now;
      cmd_fe_clear <= following_error_clear & ~prev_fec;
      prev_reached <= target_reached;
      prev_ferr <= fe_now;
    end
  end

  // ----------------------------------------------------------------
  // sequence step output
  // ----------------------------------------------------------------
  // pulse mode gives a fixed-width high pulse; plcs with slow scans
  // should keep the default toggle form, which cannot be missed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sequence_step_toggle <= 1'b0;
      seq_cnt <= '0;
    end else if (ce) begin
      if (core_seq_begin && core_seq_first) begin
        sequence_step_toggle <= 1'b0;
        seq_cnt <= '0;
      end else if (core_seq_begin) begin
        case (seq_mode)
          mtio_seq_toggle: begin
            sequence_step_toggle <= ~sequence_step_toggle;
          end
          mtio_seq_pulse: begin
            sequence_step_toggle <= 1'b1;
            seq_cnt <= SCW'(SEQ_CYC);
          end
          mtio_seq_level: sequence_step_toggle <= 1'b1;
          default: sequence_step_toggle <= ~sequence_step_toggle;
        endcase
      end else if (seq_mode == mtio_seq_pulse) begin
        if (seq_cnt > SCW'(1)) begin
          seq_cnt <= seq_cnt - SCW'(1);
        end else begin
          seq_cnt <= '0;
          sequence_step_toggle <= 1'b0;
        end
      end else if (seq_mode == mtio_seq_level && target_reached) begin
        sequence_step_toggle <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // position compare
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCMP; g++) begin : g_cmp
    mtio_poscmp #(.PW(PW)) u_cmp (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .position(core_act_pos),
      .threshold(PW'(cmp_thr[g])),
      .enable(cmode[2*g]),
      .above(cmode[2*g+1]),
      .hit(cmp_hit[g])
    );
  end

  assign position_compare_0 = cmp_hit[0];
  assign position_compare_1 = cmp_hit[1];
  assign position_compare_2 = cmp_hit[2];
  assign position_compare_3 = cmp_hit[3];
  assign position_compare_4 = cmp_hit[4];
  assign position_compare_5 = cmp_hit[5];

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[`MTIO_EV_START] = cmd_task_start | cmd_next_start | cmd_resume;
    ev[`MTIO_EV_REACHED] = target_reached & ~prev_reached;
    ev[`MTIO_EV_FERR] = fe_now & ~prev_ferr;
    ev[`MTIO_EV_SEQ] = core_seq_begin;
    ev[`MTIO_EV_JOG_END] = (state == mtio_st_jog)
        & (jog_fall | ~ctrl[`MTIO_CTRL_JOG_MODE]);
    next_irq_stat = irq_stat;
    // only the bits that the read returned are cleared; new events win
    if (rd_do && avs_address == `MTIO_OFF_IRQ) begin
      next_irq_stat = next_irq_stat & ~avs_readdata[`MTIO_EV_W-1:0];
    end
    next_irq_stat = next_irq_stat | ev;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= `MTIO_CTRL_RST;
      jog_speed <= `MTIO_JOG_RST;
      win <= `MTIO_WIN_RST;
      irq_mask <= '0;
      cmode <= `MTIO_CMODE_RST;
      for (int i = 0; i < NCMP; i++) begin
        cmp_thr[i] <= 32'h00000000;
      end
    end else if (ce && wr_do) begin
      case (avs_address)
        `MTIO_OFF_CTRL: ctrl <= `MTIO_CTRL_W'(mtio_be(32'(ctrl)));
        `MTIO_OFF_JOG: jog_speed <= mtio_be(jog_speed);
        `MTIO_OFF_WIN: win <= mtio_be(win);
        `MTIO_OFF_MASK: irq_mask <= `MTIO_EV_W'(mtio_be(32'(irq_mask)));
        `MTIO_OFF_CMODE: cmode <= (2*NCMP)'(mtio_be(32'(cmode)));
        default: begin
          for (int i = 0; i < NCMP; i++) begin
            if (avs_address == 8'(`MTIO_OFF_CMP0 + 4 * i)) begin
              cmp_thr[i] <= mtio_be(cmp_thr[i]);
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register reads and handshake
  // ----------------------------------------------------------------
  always_comb begin
    next_rd = 32'h00000000;
    case (avs_address)
      `MTIO_OFF_CTRL: next_rd = 32'(ctrl);
      `MTIO_OFF_JOG: next_rd = jog_speed;
      `MTIO_OFF_WIN: next_rd = win;
      `MTIO_OFF_STAT: begin
        next_rd[`MTIO_STAT_REACHED] = target_reached;
        next_rd[`MTIO_STAT_FERR] = fe_now;
        next_rd[`MTIO_STAT_SEQ] = sequence_step_toggle;
        next_rd[`MTIO_STAT_PEND] = pending;
        next_rd[`MTIO_STAT_STATE_LSB +: 2] = state;
        next_rd[`MTIO_STAT_TASK_LSB +: 8] = cmd_task_num;
        next_rd[`MTIO_STAT_CMP_LSB +: NCMP] = cmp_hit;
      end
      `MTIO_OFF_IRQ: next_rd = 32'(irq_stat);
      `MTIO_OFF_MASK: next_rd = 32'(irq_mask);
      `MTIO_OFF_CMODE: next_rd = 32'(cmode);
      default: begin
        for (int i = 0; i < NCMP; i++) begin
          if (avs_address == 8'(`MTIO_OFF_CMP0 + 4 * i)) begin
            next_rd = cmp_thr[i];
          end
        end
      end
    endcase
  end

  // one wait cycle: every access with ce high takes exactly two edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? next_rd : 32'h00000000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule

// File: tb/mtio_properties.sv
// assertion checker for the motion task i/o top level
// assumes binding to every mtio_top; the select, error, reached and sequence checks skip ce-low cycles, the next and jog checks do not
`timescale 1ns/100ps
module mtio_properties
  import mtio_pkg::*;
#(
  parameter int PW = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] task_select,
  input wire logic selected_task_start,
  input wire logic jog_start,
  input wire logic signed [PW-1:0] core_act_pos,
  input wire logic signed [PW-1:0] core_tgt_pos,
  input wire logic core_seq_begin,
  input wire logic core_seq_first,
  input wire logic core_following_error,
  input wire logic cmd_task_start,
  input wire logic [7:0] cmd_task_num,
  input wire logic cmd_next_start,
  input wire logic cmd_jog_run,
  input wire logic target_reached,
  input wire logic sequence_step_toggle,
  input wire logic following_error_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // jog owns the motion, so select edges are only judged outside it
  sequence s_sel_rise;
    ce && selected_task_start && !$past(selected_task_start) &&
      !$past(rst) && !jog_start && !cmd_jog_run;
  endsequence
  property p_sel_cmd;
    s_sel_rise |=> cmd_task_start;
  endproperty
  a_sel_cmd: assert property (p_sel_cmd)
    else $error("no task command");
  property p_sel_num;
    s_sel_rise |=> cmd_task_num == $past(task_select);
  endproperty
  a_sel_num: assert property (p_sel_num)
    else $error("wrong task number");
  property p_next_gated;
    cmd_next_start |-> $past(target_reached);
  endproperty
  a_next_gated: assert property (p_next_gated)
    else $error("next before reached");
  property p_jog_fall;
    $fell(jog_start) |=> !cmd_jog_run;
  endproperty
  a_jog_fall: assert property (p_jog_fall)
    else $error("jog not stopped");
  property p_jog_src;
    cmd_jog_run |-> $past(jog_start);
  endproperty
  a_jog_src: assert property (p_jog_src)
    else $error("jog without input");
  property p_fe_out;
    ce |=> following_error_out == !$past(core_following_error);
  endproperty
  a_fe_out: assert property (p_fe_out)
    else $error("error output wrong");
  property p_reached;
    ce && core_act_pos == core_tgt_pos |=> target_reached;
  endproperty
  a_reached: assert property (p_reached)
    else $error("reached low at target");
  property p_seq_first;
    ce && core_seq_begin && core_seq_first |=> !sequence_step_toggle;
  endproperty
  a_seq_first: assert property (p_seq_first)
    else $error("sequence not low");
  c_sel: cover property (s_sel_rise ##1 cmd_task_start);
  c_next: cover property (cmd_next_start);
  c_jog: cover property ($rose(cmd_jog_run));
  c_seq: cover property ($fell(sequence_step_toggle));
endmodule
bind mtio_top mtio_properties #(.PW(PW)) u_props (.*);

// File: tb/mtio_plc_model.sv
// plc model: drives task number, start, resume, jog and clear lines
// assumes one bench thread calls its tasks at a time
`timescale 1ns/100ps
module mtio_plc_model (
  input wire logic ref_clk,
  output logic [7:0] task_select,
  output logic next_task_start,
  output logic resume_task,
  output logic selected_task_start,
  output logic jog_start,
  output logic following_error_clear
);
  logic [4:0] p = 5'h00;
  logic [7:0] num = 8'h00;
  assign {following_error_clear, jog_start, selected_task_start,
          resume_task, next_task_start} = p;
  assign task_select = num;
  task set(input int w, input logic v);
    @(posedge ref_clk);
    p[w] <= v;
  endtask
  task pulse(input int w);
    set(w, 1'b1);
    set(w, 1'b0);
  endtask
  // number stands with and after the strobe, never sampled torn
  task start_sel(input logic [7:0] n);
    @(posedge ref_clk);
    num <= n;
    p[2] <= 1'b1;
    @(posedge ref_clk);
    p[2] <= 1'b0;
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the motion task i/o block
// assumes the plc model and the bound checker alongside
`timescale 1ns/100ps
`include "mtio_consts.svh"
module testbench
  import mtio_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic base_next_start = 1'b0;
  logic base_resume = 1'b0;
  logic signed [31:0] core_act_pos = 32'h0;
  logic signed [31:0] core_tgt_pos = 32'h0;
  logic core_task_active = 1'b0, core_task_interrupted = 1'b0;
  logic core_seq_begin = 1'b0, core_seq_first = 1'b0;
  logic core_following_error = 1'b0;
  logic [31:0] avs_readdata, cmd_jog_speed, q;
  logic [7:0] task_select, cmd_task_num;
  logic avs_waitrequest, irq, target_reached, sequence_step_toggle;
  logic following_error_out, cmd_task_start, cmd_next_start, cmd_resume;
  logic cmd_jog_run, cmd_jog_dir, cmd_fe_clear, following_error_clear;
  logic next_task_start, resume_task, selected_task_start, jog_start;
  logic position_compare_0, position_compare_1, position_compare_2;
  logic position_compare_3, position_compare_4, position_compare_5;
  logic [5:0] pcmp;
  assign pcmp = {position_compare_5, position_compare_4, position_compare_3,
                 position_compare_2, position_compare_1, position_compare_0};
  int miscompares = 0;
  int checks_done = 0;
  int offs[4] = '{16, 17, -16, -17};
  mtio_top dut (.*);
  mtio_plc_model plc (.*);
  always #50 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // waitrequest is read pre-update, i.e. as sampled at this edge
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      end_sim();
    end
  endtask
  // k: 0 next start, 1 resume, 2 error clear; seen within 8 cycles
  task wsee(input int k, input logic e);
    logic s;
    s = 1'b0;
    repeat (8) begin
      @(posedge ref_clk);
      s = s | (k == 0 ? cmd_next_start : k == 1 ? cmd_resume : cmd_fe_clear);
    end
    chk(s, e);
  endtask
  task seqb(input logic f);
    @(posedge ref_clk);
    core_seq_begin <= 1'b1;
    core_seq_first <= f;
    @(posedge ref_clk);
    core_seq_begin <= 1'b0;
    core_seq_first <= 1'b0;
    cyc(1);
  endtask
  task pos(input logic signed [31:0] v);
    @(posedge ref_clk);
    core_act_pos <= v;
    cyc(3);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs();
    acc(0, `MTIO_OFF_CTRL, 32'h0);
    chk(q, `MTIO_CTRL_RST);
    acc(0, `MTIO_OFF_WIN, 32'h0);
    chk(q, `MTIO_WIN_RST);
    acc(0, 8'h40, 32'h0);
    chk(q, 32'h0);
    acc(1, `MTIO_OFF_CTRL, 32'h10);
    acc(0, `MTIO_OFF_CTRL, 32'h0);
    chk(q, 32'h10);
    avs_byteenable <= 4'h1;
    acc(1, `MTIO_OFF_WIN, 32'hffffff22);
    avs_byteenable <= 4'hf;
    acc(0, `MTIO_OFF_WIN, 32'h0);
    chk(q, 32'h22);
    acc(1, `MTIO_OFF_WIN, `MTIO_WIN_RST);
    acc(1, `MTIO_OFF_CTRL, 32'h0);
    $display("t_regs done");
  endtask
  task t_sel();
    acc(1, `MTIO_OFF_MASK, 32'h0);
    plc.start_sel(8'h05);
    cyc(3);
    chk(irq, 1'b0);
    acc(1, `MTIO_OFF_MASK, 32'h1);
    acc(0, `MTIO_OFF_IRQ, 32'h0);
    foreach (offs[i]) begin
      plc.start_sel(8'hae >> i);
      cyc(1);
      chk(cmd_task_start, 1'b1);
      chk(cmd_task_num, 8'hae >> i);
      cyc(1);
      chk(cmd_task_start, 1'b0);
    end
    chk(irq, 1'b1);
    acc(0, `MTIO_OFF_IRQ, 32'h0);
    chk(q[0], 1'b1);
    cyc(2);
    chk(irq, 1'b0);
    $display("t_sel done");
  endtask
  task t_next();
    core_task_active <= 1'b1;
    pos(32'h3e8);
    plc.pulse(0);
    wsee(0, 1'b0);
    acc(0, `MTIO_OFF_STAT, 32'h0);
    chk(q[`MTIO_STAT_PEND], 1'b1);
    core_act_pos <= 32'h0;
    wsee(0, 1'b1);
    for (int e = 0; e < 2; e++) begin
      acc(1, `MTIO_OFF_CTRL, e);
      @(posedge ref_clk);
      base_next_start <= 1'b1;
      @(posedge ref_clk);
      base_next_start <= 1'b0;
      wsee(0, e[0]);
    end
    $display("t_next done");
  endtask
  task t_res();
    plc.pulse(1);
    wsee(1, 1'b0);
    core_task_interrupted <= 1'b1;
    plc.pulse(1);
    wsee(1, 1'b1);
    acc(1, `MTIO_OFF_CTRL, 32'h2);
    base_resume <= 1'b1;
    @(posedge ref_clk);
    base_resume <= 1'b0;
    wsee(1, 1'b1);
    core_task_interrupted <= 1'b0;
    $display("t_res done");
  endtask
  task t_jog();
    acc(1, `MTIO_OFF_JOG, 32'hfffffffb);
    acc(1, `MTIO_OFF_CTRL, 32'h4);
    plc.set(3, 1'b1);
    cyc(2);
    chk(cmd_jog_run, 1'b1);
    chk({cmd_jog_dir, cmd_jog_speed}, {1'b1, 32'h5});
    plc.start_sel(8'h03);
    cyc(1);
    chk(cmd_task_start, 1'b0);
    acc(1, `MTIO_OFF_JOG, 32'h7);
    cyc(2);
    chk({cmd_jog_dir, cmd_jog_speed}, {1'b0, 32'h7});
    plc.set(3, 1'b0);
    cyc(2);
    chk(cmd_jog_run, 1'b0);
    acc(1, `MTIO_OFF_CTRL, 32'h0);
    $display("t_jog done");
  endtask
  task t_seq();
    seqb(1'b1);
    chk(sequence_step_toggle, 1'b0);
    for (int i = 0; i < 3; i++) begin
      seqb(1'b0);
      chk(sequence_step_toggle, !i[0]);
    end
    acc(1, `MTIO_OFF_CTRL, 32'h8);
    seqb(1'b0);
    cyc(`MTIO_SEQ_PULSE_CYC - 1);
    chk(sequence_step_toggle, 1'b1);
    cyc(1);
    chk(sequence_step_toggle, 1'b0);
    acc(1, `MTIO_OFF_CTRL, 32'h10);
    pos(32'h3e8);
    seqb(1'b0);
    cyc(3);
    chk(sequence_step_toggle, 1'b1);
    pos(32'h0);
    chk(sequence_step_toggle, 1'b0);
    acc(1, `MTIO_OFF_CTRL, 32'h0);
    $display("t_seq done");
  endtask
  task t_misc();
    ce <= 1'b0;
    core_following_error <= 1'b1;
    cyc(2);
    chk(following_error_out, 1'b1);
    ce <= 1'b1;
    cyc(2);
    chk(following_error_out, 1'b0);
    core_following_error <= 1'b0;
    cyc(2);
    chk(following_error_out, 1'b1);
    plc.pulse(4);
    wsee(2, 1'b1);
    core_tgt_pos <= 32'h64;
    foreach (offs[i]) begin
      pos(32'h64 + offs[i]);
      chk(target_reached, !i[0]);
    end
    for (int i = 0; i < 6; i++) begin
      acc(1, `MTIO_OFF_CMP0 + 8'(4 * i), 32'h64);
    end
    acc(1, `MTIO_OFF_CMODE, 32'hfff);
    pos(32'hc8);
    chk(pcmp, 6'h3f);
    acc(1, `MTIO_OFF_CMODE, 32'h555);
    pos(32'h32);
    chk(pcmp, 6'h3f);
    pos(32'hc8);
    chk(position_compare_0, 1'b0);
    $display("t_misc done");
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_sel();
    t_next();
    t_res();
    t_jog();
    t_seq();
    t_misc();
    end_sim();
  end
endmodule
